// ==== logic/fcc_ctrl.sv ====
// FEAC codeword controller: transmit code sequencer and receive detector.
// Assumes the framer offers one FEAC bit slot per strobe on CLK_I, and
// the processor ports are synchronous to CLK_I.
//
// Overview of operation
// - Code bit 1 arrives first, sits at bit 0.
// - Two transmit codes, first-sent bit at bit 0.
// - Idle mode sends continuous ones.
// - Single mode: code A ten times, then ones.
// - Dual mode: A ten times, B ten times.
// - Continuous mode repeats code A until changed.
// - Codeword: zero, six code bits, zero, ones.
// - Search for codeword at every bit position.
// - Three equal codewords set detect, push FIFO.
// - Two differing codewords or idle clear detect.
// - Sixteen consecutive ones declare receive idle.
// - Receive idle ends when detect sets.
// - FIFO holds four whole six-bit codes.
// - FIFO reports empty when it holds nothing.
// - Code arriving while full is dropped, overflow.
// - Reading an empty FIFO changes nothing.
// - Transmit and receive sides run independently.
`timescale 1ns/1ps
`include "fcc_defines.svh"

module fcc_ctrl (
    input  wire logic                 CLK_I,             // 40 MHz clock.
    input  wire logic                 RST_B_I,           // Async reset, active low.
    input  fcc_pkg::fcc_tx_mode_t     TX_MODE_I,         // Transmit mode.
    input  wire fcc_pkg::fcc_code_t   TX_CODE_FIRST_I,   // Code A.
    input  wire fcc_pkg::fcc_code_t   TX_CODE_SECOND_I,  // Code B.
    input  wire logic                 TX_BIT_EN_I,       // Transmit bit slot.
    output logic                      TX_FEAC_O,         // Outgoing FEAC bit.
    output logic                      TX_BUSY_O,         // Codewords in flight.
    input  wire logic                 RX_BIT_I,          // Incoming FEAC bit.
    input  wire logic                 RX_BIT_EN_I,       // Receive bit slot.
    input  wire logic                 RX_FIFO_RD_I,      // Pop one code.
    input  wire logic                 RX_OVF_CLR_I,      // Clear overflow.
    output fcc_pkg::fcc_code_t        RX_CODE_FIFO_OUT_O, // Popped code.
    output logic                      RX_CODE_VALID_O,   // Pulse: code fresh.
    output fcc_pkg::fcc_rx_stat_t     RX_STATUS_O        // Receive status.
);
    import fcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Codeword helpers.

    // Build a codeword; index 15 goes out first.
    function automatic logic [`FCC_CW_W-1:0] cw_build(input fcc_code_t c);
        cw_build = {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0,
                    `FCC_ONES_TAIL};
    endfunction : cw_build

    // Recover the code from a window whose oldest bit is index 15.
    function automatic fcc_code_t cw_code(input logic [`FCC_CW_W-1:0] w);
        cw_code = {w[9], w[10], w[11], w[12], w[13], w[14]};
    endfunction : cw_code

    function automatic logic cw_match(input logic [`FCC_CW_W-1:0] w);
        cw_match = !w[15] && !w[8] && (w[7:0] == `FCC_ONES_TAIL);
    endfunction : cw_match

    ////////////////////////////////////////////////////////////////////////
    // Transmit sequencer.

    typedef enum logic [1:0] {TXS_IDLE, TXS_A, TXS_B, TXS_ONES} fcc_txs_t;

    fcc_txs_t     txs_reg;
    fcc_txs_t     txs_next;
    fcc_tx_mode_t mode_reg;
    logic [3:0]   bit_cnt_reg;
    logic [3:0]   bit_cnt_next;
    logic [3:0]   cw_cnt_reg;
    logic [3:0]   cw_cnt_next;
    logic         tx_bit_reg;
    logic         tx_bit_next;
    logic         busy_reg;

    // Code B only during its ten words.
    wire fcc_code_t tx_code = (txs_reg == TXS_B) ? TX_CODE_SECOND_I
                                                 : TX_CODE_FIRST_I;
    wire [`FCC_CW_W-1:0] tx_word = cw_build(tx_code);
    wire tx_sending  = (txs_reg == TXS_A) || (txs_reg == TXS_B);
    wire tx_word_end = TX_BIT_EN_I && tx_sending
                       && (bit_cnt_reg == `FCC_BIT_LAST);
    wire tx_last_cw  = (cw_cnt_reg == `FCC_CW_LAST);
    // A mode change restarts the sequence on the next cycle.
    wire mode_chg    = (TX_MODE_I != mode_reg);

    always_comb begin
        txs_next     = txs_reg;
        bit_cnt_next = bit_cnt_reg;
        cw_cnt_next  = cw_cnt_reg;
        tx_bit_next  = tx_bit_reg;
        if (mode_chg) begin
            txs_next     = (TX_MODE_I == FCC_MODE_IDLE) ? TXS_IDLE : TXS_A;
            bit_cnt_next = `FCC_BIT_FIRST;
            cw_cnt_next  = `FCC_CW_FIRST;
        end else if (TX_BIT_EN_I) begin
            tx_bit_next = 1'b1;
            if (tx_sending) begin
                tx_bit_next  = tx_word[4'(`FCC_BIT_LAST - bit_cnt_reg)];
                bit_cnt_next = 4'(bit_cnt_reg + 1'b1);
            end
            if (tx_word_end) begin
                cw_cnt_next = tx_last_cw ? `FCC_CW_FIRST
                                         : 4'(cw_cnt_reg + 1'b1);
                case (txs_reg)
                    TXS_A: begin
                        if (mode_reg == FCC_MODE_CONT) begin
                            cw_cnt_next = `FCC_CW_FIRST;
                        end else if (tx_last_cw) begin
                            txs_next = (mode_reg == FCC_MODE_DUAL) ? TXS_B
                                                                   : TXS_ONES;
                        end
                    end
                    TXS_B: begin
                        if (tx_last_cw) begin
                            txs_next = TXS_ONES;
                        end
                    end
                    default: begin
                        txs_next = txs_reg;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            txs_reg     <= TXS_IDLE;
            mode_reg    <= FCC_MODE_IDLE;
            bit_cnt_reg <= `FCC_BIT_FIRST;
            cw_cnt_reg  <= `FCC_CW_FIRST;
            tx_bit_reg  <= 1'b1;
            busy_reg    <= 1'b0;
        end else begin
            txs_reg     <= txs_next;
            mode_reg    <= TX_MODE_I;
            bit_cnt_reg <= bit_cnt_next;
            cw_cnt_reg  <= cw_cnt_next;
            tx_bit_reg  <= tx_bit_next;
            busy_reg    <= (txs_next == TXS_A) || (txs_next == TXS_B);
        end
    end

    assign TX_FEAC_O = tx_bit_reg;
    assign TX_BUSY_O = busy_reg;

    ////////////////////////////////////////////////////////////////////////
    // Receive detector. It shares nothing with the transmit side.

    logic [`FCC_CW_W-1:0] rx_sr_reg;
    logic [4:0]           ones_reg;
    fcc_code_t            cand_reg;
    logic [1:0]           cand_cnt_reg;
    logic [1:0]           miss_reg;
    fcc_code_t            cur_reg;
    logic                 det_reg;
    logic                 idle_reg;
    logic                 ovf_reg;

    wire [`FCC_CW_W-1:0] rx_sr_next = {rx_sr_reg[`FCC_CW_W-2:0], RX_BIT_I};
    // Every bit position is a candidate boundary.
    wire       rx_hit   = RX_BIT_EN_I && cw_match(rx_sr_next);
    wire fcc_code_t rx_code = cw_code(rx_sr_next);
    wire       same     = (rx_code == cand_reg);
    wire       idle_hit = RX_BIT_EN_I && RX_BIT_I
                          && (ones_reg == `FCC_ONES_PRE);
    // The third equal codeword in a row sets detect.
    wire       det_set  = rx_hit && same && (cand_cnt_reg == `FCC_DET_PRE)
                          && !(det_reg && (rx_code == cur_reg));
    wire       differ   = rx_hit && det_reg && (rx_code != cur_reg);
    wire       det_clr  = (differ && (miss_reg == `FCC_MISS_PRE))
                          || idle_hit;
    wire       fifo_rdy;
    wire       fifo_has;
    wire       ovf_set  = det_set && !fifo_rdy;

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rx_sr_reg    <= '0;
            ones_reg     <= '0;
            cand_reg     <= '0;
            cand_cnt_reg <= '0;
            miss_reg     <= '0;
            cur_reg      <= '0;
            det_reg      <= 1'b0;
            idle_reg     <= 1'b0;
            ovf_reg      <= 1'b0;
        end else begin
            if (RX_BIT_EN_I) begin
                rx_sr_reg <= rx_sr_next;
                ones_reg  <= !RX_BIT_I ? 5'h00 :
                             (ones_reg == `FCC_ONES_SAT) ? ones_reg :
                             5'(ones_reg + 1'b1);
            end
            if (idle_hit) begin
                cand_cnt_reg <= '0;
            end else if (rx_hit) begin
                cand_reg     <= rx_code;
                cand_cnt_reg <= !same ? `FCC_CNT_ONE :
                                (cand_cnt_reg == `FCC_DET_SAT) ? cand_cnt_reg :
                                2'(cand_cnt_reg + 1'b1);
            end
            if (rx_hit) begin
                miss_reg <= differ ? 2'(miss_reg + 1'b1) : 2'h0;
            end
            if (det_set) begin
                cur_reg <= rx_code;
            end
            // For detect and overflow, setting beats clearing in the same cycle.
            det_reg  <= det_set | (det_reg & ~det_clr);
            idle_reg <= ~det_set & (idle_hit | idle_reg);
            ovf_reg  <= ovf_set | (ovf_reg & ~RX_OVF_CLR_I);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive code FIFO.

    fcc_fifo #(
        .WIDTH (`FCC_CODE_W),
        .DEPTH (`FCC_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .in_valid_i  (det_set),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (rx_code),
        .out_valid_o (fifo_has),
        .out_ready_i (RX_FIFO_RD_I),
        .out_data_o  (RX_CODE_FIFO_OUT_O),
        .out_strb_o  (RX_CODE_VALID_O)
    );

    assign RX_STATUS_O = '{code_det:   det_reg,
                           rx_idle:    idle_reg,
                           overflow:   ovf_reg,
                           fifo_empty: !fifo_has};

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_word_end;
        TX_BIT_EN_I && tx_sending && bit_cnt_reg == 4'hf && !mode_chg;
    endsequence

    a_idle_sends_ones: assert property (
        (txs_reg == TXS_IDLE && TX_BIT_EN_I && !mode_chg) |=> TX_FEAC_O)
        else $error("Idle mode sent a zero.");

    a_code_bit_order: assert property (
        (txs_reg == TXS_A && bit_cnt_reg == 4'h1 && TX_BIT_EN_I && !mode_chg)
        |=> (TX_FEAC_O == $past(TX_CODE_FIRST_I[0])))
        else $error("First code bit not taken from bit 0.");

    a_single_tenth_word: assert property (
        (s_word_end and (txs_reg == TXS_A && cw_cnt_reg == 4'h9
                         && mode_reg == FCC_MODE_SINGLE))
        |=> (txs_reg == TXS_ONES))
        else $error("Single mode did not stop after ten words.");

    a_dual_to_second: assert property (
        (s_word_end and (txs_reg == TXS_A && cw_cnt_reg == 4'h9
                         && mode_reg == FCC_MODE_DUAL))
        |=> (txs_reg == TXS_B && cw_cnt_reg == 4'h0))
        else $error("Dual mode did not move to code B.");

    a_cont_keeps_going: assert property (
        (s_word_end and (txs_reg == TXS_A && mode_reg == FCC_MODE_CONT))
        |=> (txs_reg == TXS_A))
        else $error("Continuous mode stopped.");

    a_idle_after_ones: assert property (
        (idle_hit && !det_set) |=> (idle_reg && !det_reg))
        else $error("Sixteen ones did not declare idle.");

    a_detect_push: assert property (
        $rose(det_reg) |-> ($past(det_set) && !idle_reg
                           && cur_reg == $past(rx_code)))
        else $error("Detect rose without a three-word match.");

    a_overflow_full: assert property (
        (det_set && !fifo_rdy) |=> (ovf_reg && $stable(fifo_has)))
        else $error("Code into a full FIFO did not flag overflow.");

    // Code B must use the same bit order as code A.
    a_second_bit_order: assert property (
        (txs_reg == TXS_B && bit_cnt_reg == 4'h1 && TX_BIT_EN_I && !mode_chg)
        |=> (TX_FEAC_O == $past(TX_CODE_SECOND_I[0])))
        else $error("Code B first bit not taken from bit 0.");

    a_two_miss_clear: assert property (
        (differ && miss_reg == `FCC_MISS_PRE && !det_set) |=> !det_reg)
        else $error("Two differing codewords did not clear detect.");

    a_detect_ends_idle: assert property (
        det_set |=> (!idle_reg && det_reg))
        else $error("Detect did not end receive idle.");

endmodule : fcc_ctrl

// ==== logic/fcc_defines.svh ====
// Constants for the FEAC codeword controller: widths, counts, patterns.
// Assumes inclusion by the package and by every design file that needs them.
`ifndef FCC_DEFINES_SVH
`define FCC_DEFINES_SVH

`define FCC_CODE_W     6
`define FCC_CW_W       16
`define FCC_BIT_LAST   4'hf
`define FCC_BIT_FIRST  4'h0
`define FCC_CW_LAST    4'h9
`define FCC_CW_FIRST   4'h0
`define FCC_DET_PRE    2'h2
`define FCC_DET_SAT    2'h3
`define FCC_CNT_ONE    2'h1
`define FCC_MISS_PRE   2'h1
`define FCC_ONES_PRE   5'h0f
`define FCC_ONES_SAT   5'h10
`define FCC_ONES_TAIL  8'hff
`define FCC_FIFO_DEPTH 4

`endif

// ==== logic/fcc_pkg.sv ====
// Types shared by the FEAC codeword controller files.
// Assumes fcc_defines.svh sits in the include path.
`include "fcc_defines.svh"

package fcc_pkg;

    typedef logic [`FCC_CODE_W-1:0] fcc_code_t;

    typedef enum logic [1:0] {
        FCC_MODE_IDLE,
        FCC_MODE_SINGLE,
        FCC_MODE_DUAL,
        FCC_MODE_CONT
    } fcc_tx_mode_t;

    typedef struct packed {
        logic code_det;
        logic rx_idle;
        logic overflow;
        logic fifo_empty;
    } fcc_rx_stat_t;

endpackage : fcc_pkg

// ==== logic/fcc_fifo.sv ====
// Small code FIFO with a registered read port.
// Assumes one clock; pops are requests that the FIFO ignores while empty.
`timescale 1ns/1ps
`include "fcc_defines.svh"

module fcc_fifo #(
    parameter int WIDTH = `FCC_CODE_W,
    parameter int DEPTH = `FCC_FIFO_DEPTH
) (
    input  wire logic             clk_i,       // Clock.
    input  wire logic             rst_b_i,     // Asynchronous reset, active low.
    input  wire logic             in_valid_i,  // Write request.
    output logic                  in_ready_o,  // Room for one word.
    input  wire logic [WIDTH-1:0] in_data_i,   // Write data.
    output logic                  out_valid_o, // At least one word stored.
    input  wire logic             out_ready_i, // Pop request.
    output logic [WIDTH-1:0]      out_data_o,  // Last popped word.
    output logic                  out_strb_o   // Pulse: out_data_o fresh.
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    logic [WIDTH-1:0] data_reg;
    logic             strb_reg;
    logic             full_reg;
    logic             empty_reg;
    wire              do_wr = in_valid_i & ~full_reg;
    wire              do_rd = out_ready_i & ~empty_reg;

    assign count_next  = count_reg + CW'(do_wr) - CW'(do_rd);
    assign in_ready_o  = ~full_reg;
    assign out_valid_o = ~empty_reg;
    assign out_data_o  = data_reg;
    assign out_strb_o  = strb_reg;

    // Storage has no reset so it maps onto plain memory cells.
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            full_reg   <= 1'b0;
            empty_reg  <= 1'b1;
            data_reg   <= '0;
            strb_reg   <= 1'b0;
        end else begin
            wr_ptr_reg <= do_wr ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= do_rd ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg  <= count_next;
            full_reg   <= (count_next == CW'(DEPTH));
            empty_reg  <= (count_next == '0);
            data_reg   <= do_rd ? mem_reg[rd_ptr_reg] : data_reg;
            strb_reg   <= do_rd;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_empty_read_ignored: assert property (
        (out_ready_i && empty_reg && !in_valid_i) |=>
            ($stable(rd_ptr_reg) && count_reg == '0 && !strb_reg))
        else $error("Read of an empty FIFO changed its state.");

    a_empty_flag_true: assert property (
        (count_reg == '0) == empty_reg)
        else $error("Empty flag disagrees with the fill level.");

endmodule : fcc_fifo

// ==== tb/fcc_far_model.sv ====
// Far-end model: framer FEAC bit slots on the transmit and receive paths.
// Assumes the controller's clock; the bench calls the tasks by hierarchy.
`timescale 1ns/1ps

module fcc_far_model (
    input  wire logic clk_i,       // Clock.
    input  wire logic tx_feac_i,   // Controller FEAC bit.
    output logic      tx_bit_en_o, // Transmit bit slot.
    output logic      rx_bit_o,    // Received FEAC bit.
    output logic      rx_bit_en_o  // Receive bit slot.
);
    logic cap[$];

    initial begin
        tx_bit_en_o = 1'b0;
        rx_bit_o    = 1'b1;
        rx_bit_en_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // A nonzero gap leaves idle cycles between slots, as a slow framer would.
    task automatic take_bits(input int n, input int gap);
        @(posedge clk_i);
        tx_bit_en_o <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            if (gap != 0 || i == n - 1) begin
                tx_bit_en_o <= 1'b0;
            end
            @(negedge clk_i);
            cap.push_back(tx_feac_i);
            if (gap != 0 && i != n - 1) begin
                repeat (gap) @(posedge clk_i);
                tx_bit_en_o <= 1'b1;
            end
        end
    endtask : take_bits

    ////////////////////////////////////////////////////////////////////////////
    // Between slots the line shows the inverse bit, so stale data never helps.
    task automatic rx_bits(input logic [15:0] w, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_bit_o    <= w[15-i];
            rx_bit_en_o <= 1'b1;
            if (gap != 0) begin
                @(posedge clk_i);
                rx_bit_en_o <= 1'b0;
                rx_bit_o    <= ~w[15-i];
                repeat (gap - 1) @(posedge clk_i);
            end
        end
        @(posedge clk_i);
        rx_bit_en_o <= 1'b0;
        rx_bit_o    <= ~w[16-n];
    endtask : rx_bits

endmodule : fcc_far_model

// ==== tb/test_feac_codeword_controller.sv ====
// Self-checking bench for the FEAC codeword controller.
// Assumes fcc_pkg is compiled first and the far-end model drives bit slots.
`timescale 1ns/1ps

module test_feac_codeword_controller
    import fcc_pkg::*;
;
    logic         clk;
    logic         rst_b;
    fcc_tx_mode_t mode;
    fcc_code_t    code_a;
    fcc_code_t    code_b;
    logic         rd;
    logic         ovf_clr;
    logic         tx_en;
    logic         tx_feac;
    logic         tx_busy;
    logic         rx_bit;
    logic         rx_en;
    fcc_code_t    rx_code;
    logic         rx_valid;
    fcc_rx_stat_t rx_stat;
    int           n_fail;
    int           samples_checked;
    logic         exp_q[$];
    fcc_code_t    tbl[5] = '{6'h01, 6'h12, 6'h24, 6'h38, 6'h0e};

    fcc_ctrl i_dut (
        .CLK_I(clk), .RST_B_I(rst_b), .TX_MODE_I(mode),
        .TX_CODE_FIRST_I(code_a), .TX_CODE_SECOND_I(code_b),
        .TX_BIT_EN_I(tx_en), .TX_FEAC_O(tx_feac), .TX_BUSY_O(tx_busy),
        .RX_BIT_I(rx_bit), .RX_BIT_EN_I(rx_en), .RX_FIFO_RD_I(rd),
        .RX_OVF_CLR_I(ovf_clr), .RX_CODE_FIFO_OUT_O(rx_code),
        .RX_CODE_VALID_O(rx_valid), .RX_STATUS_O(rx_stat)
    );

    fcc_far_model i_far (
        .clk_i(clk), .tx_feac_i(tx_feac), .tx_bit_en_o(tx_en),
        .rx_bit_o(rx_bit), .rx_bit_en_o(rx_en)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [15:0] cw(input fcc_code_t c);
        return {1'b0, c[0], c[1], c[2], c[3], c[4], c[5], 1'b0, 8'hff};
    endfunction : cw

    task automatic add_bits(input logic [15:0] w, input int n);
        for (int b = 0; b < n; b++) begin
            exp_q.push_back(w[15-b]);
        end
    endtask : add_bits

    task automatic run_tx(input int n, input int gap);
        i_far.cap.delete();
        i_far.take_bits(n, gap);
        chk(16'(i_far.cap.size()), 16'(exp_q.size()), "tx length");
        for (int i = 0; i < n && i < exp_q.size(); i++) begin
            chk(16'(i_far.cap[i]), 16'(exp_q[i]), "tx bit");
        end
        exp_q.delete();
    endtask : run_tx

    task automatic set_mode(input fcc_tx_mode_t m);
        @(posedge clk);
        mode <= m;
    endtask : set_mode

    task automatic st(input logic [3:0] e);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(16'(rx_stat), 16'(e), "status");
    endtask : st

    task automatic rx_words(input fcc_code_t c, input int n, input int gap);
        for (int k = 0; k < n; k++) begin
            i_far.rx_bits(cw(c), 16, gap);
        end
    endtask : rx_words

    task automatic rd_chk(input fcc_code_t e, input logic v);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(16'(rx_valid), 16'(v), "read pulse");
        chk(16'(rx_code), 16'(e), "read code");
        @(negedge clk);
        chk(16'(rx_valid), 16'h0000, "pulse width");
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////
    task automatic sc_tx();
        set_mode(FCC_MODE_SINGLE);
        add_bits(cw(code_a), 16);
        for (int k = 1; k < 10; k++) add_bits(cw(code_a), 16);
        add_bits(16'hffff, 1);
        run_tx(161, 0);
        chk(16'(tx_busy), 16'h0000, "busy after single");
        set_mode(FCC_MODE_DUAL);
        for (int k = 0; k < 10; k++) add_bits(cw(code_a), 16);
        for (int k = 0; k < 10; k++) add_bits(cw(code_b), 16);
        add_bits(16'hffff, 1);
        run_tx(321, 2);
        set_mode(FCC_MODE_CONT);
        for (int k = 0; k < 12; k++) add_bits(cw(code_a), 16);
        add_bits(cw(code_a), 8);
        run_tx(200, 0);
        chk(16'(tx_busy), 16'h0001, "busy in continuous");
        // Leaving continuous mode in mid-word must drop straight to ones.
        set_mode(FCC_MODE_IDLE);
        add_bits(16'hffff, 16);
        add_bits(16'hffff, 16);
        run_tx(32, 1);
    endtask : sc_tx

    // Receive runs with transmit bit slots stopped.
    task automatic sc_rx();
        i_far.rx_bits(16'hb000, 5, 0);
        i_far.rx_bits(16'hffff, 16, 0);
        st(4'h5);
        rx_words(6'h05, 2, 0);
        st(4'h5);
        rx_words(6'h05, 1, 1);
        st(4'h8);
        rx_words(6'h2e, 1, 0);
        st(4'h8);
        rx_words(6'h2e, 1, 0);
        st(4'h0);
        rx_words(6'h13, 3, 1);
        st(4'h8);
        i_far.rx_bits(16'hffff, 16, 0);
        st(4'h4);
        rd_chk(6'h05, 1'b1);
        rd_chk(6'h13, 1'b1);
        st(4'h5);
        rd_chk(6'h13, 1'b0);
        st(4'h5);
    endtask : sc_rx

    task automatic sc_ovf();
        for (int k = 0; k < 5; k++) begin
            rx_words(tbl[k], 3, k % 2);
            i_far.rx_bits(16'hffff, 16, 0);
        end
        st(4'h6);
        for (int k = 0; k < 4; k++) begin
            rd_chk(tbl[k], 1'b1);
        end
        st(4'h7);
        @(posedge clk);
        ovf_clr <= 1'b1;
        @(posedge clk);
        ovf_clr <= 1'b0;
        st(4'h5);
    endtask : sc_ovf

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail          = 0;
        samples_checked = 0;
        rst_b           = 1'b0;
        mode            = FCC_MODE_IDLE;
        code_a          = 6'h00;
        code_b          = 6'h00;
        rd              = 1'b0;
        ovf_clr         = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk(16'(tx_feac), 16'h0001, "reset bit");
        chk(16'(tx_busy), 16'h0000, "reset busy");
        chk(16'(rx_stat), 16'h0001, "reset status");
        @(posedge clk);
        code_a <= 6'h0b;
        code_b <= 6'h31;
        sc_tx();
        sc_rx();
        sc_ovf();
        end_of_test();
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("wrong value at %0t: run did not finish", $time);
        end_of_test();
    end

endmodule : test_feac_codeword_controller
